//--- common/fpoc_pkg.sv
// Purpose: constants and carriers for the fault persistence / overload config block
// Assumes: 16-bit registers reached by a simple register port, offsets chosen locally
// Notes: persistence codes 000..101 give 1..32 conversions, 110/111 reserved
package fpoc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [1:0] ADDR_OVERLOAD = 2'h0;
    localparam logic [1:0] ADDR_IN_PERSIST = 2'h1;
    localparam logic [1:0] ADDR_OUT_PERSIST_ONE = 2'h2;
    localparam logic [15:0] RST_OVERLOAD = 16'h0000;
    localparam logic [15:0] RST_IN_PERSIST = 16'h0000;
    localparam logic [15:0] RST_OUT_PERSIST_ONE = 16'h0000;
    // implemented bits of the persistence registers
    localparam logic [15:0] MASK_IN_PERSIST = 16'hE7E0;
    localparam logic [15:0] MASK_OUT_PERSIST_ONE = 16'hE0E0;
    // ****************************************
    // field positions
    // ****************************************
    localparam int CLASS_LSB = 14;
    localparam int FACTOR_HI_LSB = 8;
    localparam int FACTOR_LO_BIT = 7;
    localparam int BASE_LSB = 0;
    localparam int UV_LSB = 13;
    localparam int LD_LSB = 8;
    localparam int OV_LSB = 5;
    localparam logic [2:0] PERSIST_MAX_CODE = 3'h5;
    localparam logic [5:0] PERSIST_CNT_RST = 6'h00;
    // shunt voltage per base-step unit, in nanovolts
    localparam int BASE_UNIT_NV = 25000;

    typedef enum logic [3:0] {
        FPOC_CLASS0 = 4'h1,
        FPOC_CLASS1 = 4'h2,
        FPOC_CLASS2 = 4'h4,
        FPOC_CLASS3 = 4'h8
    } fpoc_class_e;

    // register port request
    typedef struct packed {
        logic wr;
        logic [1:0] addr;
        logic [15:0] wdata;
    } fpoc_req_s;

    // condition flags of one conversion
    typedef struct packed {
        logic in_uv;
        logic ld;
        logic in_ov;
        logic out_uv;
        logic out_ov;
    } fpoc_cond_s;
endpackage : fpoc_pkg

//--- hdl/fpoc_regs.sv
// Purpose: overload and voltage persistence registers with fault qualification
// Assumes: register requests and conversion strobes are synchronous to clk_i
// Notes: persistence registers are frozen while the converter runs
`timescale 1ns/10ps
`default_nettype none
module fpoc_regs (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire fpoc_pkg::fpoc_req_s req_i,
    input wire logic req_valid_i,
    output logic [15:0] rdata_o,
    input wire logic conv_en_i,
    input wire logic conv_valid_i,
    input wire fpoc_pkg::fpoc_cond_s cond_i,
    output fpoc_pkg::fpoc_cond_s fault_o,
    output fpoc_pkg::fpoc_class_e ovl_class_o,
    output logic [6:0] ovl_factor_o,
    output logic [6:0] ovl_base_o,
    output logic [13:0] ovl_threshold_o
);
    logic [15:0] ovl_r;
    logic [15:0] inp_r;
    logic [15:0] outp_r;
    logic [15:0] rdata_nxt;
    logic [2:0] code_w [5];
    logic [5:0] cnt_r [5];
    logic [4:0] cond_w;
    logic [4:0] fault_r;
    logic ovl_wr_w;
    logic persist_wr_w;
    logic rd_w;
    logic conv_w;
    logic [4:0] hit_w;

    // number of conversions required for a code, reserved codes need 63
    function automatic logic [5:0] persist_need(input logic [2:0] code);
        if (code > fpoc_pkg::PERSIST_MAX_CODE) begin
            persist_need = 6'h3F; // reserved code, needs 63 conversions
        end else begin
            persist_need = 6'(6'h01 << code);
        end
    endfunction : persist_need

    // sample completes the required run: count plus this sample reaches need
    function automatic logic persist_hit(input logic [5:0] cnt, input logic [2:0] code);
        persist_hit = (7'(cnt) + 7'h01) >= 7'(persist_need(code));
    endfunction : persist_hit

    // one-hot class from the two class bits
    function automatic fpoc_pkg::fpoc_class_e class_decode(input logic [1:0] code);
        case (code)
            2'h0: class_decode = fpoc_pkg::FPOC_CLASS0; // no overload handling
            2'h1: class_decode = fpoc_pkg::FPOC_CLASS1;
            2'h2: class_decode = fpoc_pkg::FPOC_CLASS2;
            default: class_decode = fpoc_pkg::FPOC_CLASS3;
        endcase
    endfunction : class_decode

    // seven-bit multiplier gathered from its split positions
    function automatic logic [6:0] factor_field(input logic [15:0] word);
        factor_field = {word[fpoc_pkg::FACTOR_HI_LSB +: 6], word[fpoc_pkg::FACTOR_LO_BIT]};
    endfunction : factor_field

    // threshold as multiplier times base step, full 14-bit product
    function automatic logic [13:0] threshold_calc(input logic [6:0] factor,
                                                   input logic [6:0] base);
        threshold_calc = 14'(factor) * 14'(base);
    endfunction : threshold_calc

    // ****************************************
    // behaviour notes
    // ****************************************
    // the lock only gates persistence writes; overload stays writable
    // a write to a locked register is dropped without any error flag
    // decoded overload outputs lag the register by one enabled clock
    // a reserved code keeps its fault low however long the condition lasts
    // samples count only on conversion strobes; idle cycles neither count nor clear
    // a counter saturates at its need so a long condition cannot wrap it
    // ce_i low freezes registers, counters, flags and read data alike
    // the threshold is in base-step units, scaled by the shunt outside

    // ****************************************
    // register writes
    // ****************************************
    // request decodes shared by the write and read processes
    assign ovl_wr_w = ce_i && req_valid_i && req_i.wr && req_i.addr == fpoc_pkg::ADDR_OVERLOAD;
    assign persist_wr_w = ce_i && req_valid_i && req_i.wr && !conv_en_i;
    assign rd_w = ce_i && req_valid_i && !req_i.wr;
    assign conv_w = ce_i && conv_valid_i;

    // overload register is writable whenever ce_i is high
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ovl_r <= fpoc_pkg::RST_OVERLOAD;
        end else if (ovl_wr_w) begin
            ovl_r <= req_i.wdata;
        end
    end

    // persistence registers, locked while running
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inp_r <= fpoc_pkg::RST_IN_PERSIST;
            outp_r <= fpoc_pkg::RST_OUT_PERSIST_ONE;
        end else if (persist_wr_w) begin
            if (req_i.addr == fpoc_pkg::ADDR_IN_PERSIST) begin
                inp_r <= req_i.wdata & fpoc_pkg::MASK_IN_PERSIST;
            end
            if (req_i.addr == fpoc_pkg::ADDR_OUT_PERSIST_ONE) begin
                outp_r <= req_i.wdata & fpoc_pkg::MASK_OUT_PERSIST_ONE;
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // read mux, unmapped address reads zero
    always_comb begin
        case (req_i.addr)
            fpoc_pkg::ADDR_OVERLOAD: rdata_nxt = ovl_r;
            fpoc_pkg::ADDR_IN_PERSIST: rdata_nxt = inp_r;
            fpoc_pkg::ADDR_OUT_PERSIST_ONE: rdata_nxt = outp_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // read data registered on a read request
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_w) begin
            rdata_o <= rdata_nxt;
        end
    end

    // ****************************************
    // overload decode
    // ****************************************
    // class, factor, base and threshold outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ovl_class_o <= fpoc_pkg::FPOC_CLASS0;
            ovl_factor_o <= 7'h00;
            ovl_base_o <= 7'h00;
            ovl_threshold_o <= 14'h0000;
        end else if (ce_i) begin
            ovl_class_o <= class_decode(ovl_r[fpoc_pkg::CLASS_LSB +: 2]);
            ovl_factor_o <= factor_field(ovl_r);
            ovl_base_o <= ovl_r[fpoc_pkg::BASE_LSB +: 7];
            ovl_threshold_o <= threshold_calc(factor_field(ovl_r),
                                              ovl_r[fpoc_pkg::BASE_LSB +: 7]);
        end
    end

    // ****************************************
    // persistence qualification
    // ****************************************
    // field and condition per channel: uv, ld, ov, out uv, out ov
    assign code_w[0] = inp_r[fpoc_pkg::UV_LSB +: 3];
    assign code_w[1] = inp_r[fpoc_pkg::LD_LSB +: 3];
    assign code_w[2] = inp_r[fpoc_pkg::OV_LSB +: 3];
    assign code_w[3] = outp_r[fpoc_pkg::UV_LSB +: 3];
    assign code_w[4] = outp_r[fpoc_pkg::OV_LSB +: 3];
    assign cond_w = cond_i;

    // a present condition completes its run on this sample
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            hit_w[i] = cond_w[4 - i] && persist_hit(cnt_r[i], code_w[i]);
        end
    end

    // consecutive-conversion counters, saturating at the need
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 5; i++) begin
                cnt_r[i] <= fpoc_pkg::PERSIST_CNT_RST;
            end
        end else if (conv_w) begin
            for (int i = 0; i < 5; i++) begin
                if (!cond_w[4 - i]) begin
                    cnt_r[i] <= fpoc_pkg::PERSIST_CNT_RST;
                end else if (hit_w[i]) begin
                    cnt_r[i] <= persist_need(code_w[i]);
                end else begin
                    cnt_r[i] <= cnt_r[i] + 6'h01;
                end
            end
        end
    end

    // fault flags: set on the completing sample, cleared by a quiet one
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_r <= 5'h00;
        end else if (conv_w) begin
            for (int i = 0; i < 5; i++) begin
                fault_r[4 - i] <= hit_w[i] && (code_w[i] <= fpoc_pkg::PERSIST_MAX_CODE);
            end
        end
    end

    assign fault_o = fault_r;
endmodule : fpoc_regs
`default_nettype wire

//--- testbench/fpoc_regs_props.sv
// Purpose: port relations of fpoc_regs
// Assumes: one clock domain, async active-low reset
// Notes: attached by the bind at the foot
`timescale 1ns/10ps
`default_nettype none
module fpoc_regs_props (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic conv_valid_i,
    input wire logic [15:0] rdata_o,
    input wire fpoc_pkg::fpoc_req_s req_i,
    input wire fpoc_pkg::fpoc_cond_s cond_i,
    input wire fpoc_pkg::fpoc_cond_s fault_o,
    input wire fpoc_pkg::fpoc_class_e ovl_class_o,
    input wire logic [6:0] ovl_factor_o,
    input wire logic [6:0] ovl_base_o,
    input wire logic [13:0] ovl_threshold_o
);
    // clocking and request decodes
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic ow = ce_i && req_valid_i && req_i.wr && req_i.addr == 2'h0;
    wire logic rd = ce_i && req_valid_i && !req_i.wr;
    wire logic cv = ce_i && conv_valid_i;
    wire logic [15:0] wd = req_i.wdata;
    // overload fields land two edges after a write
    AST_CLASS: assert property (ow ##1 ce_i |=> ovl_class_o == 4'h1 << $past(wd[15:14], 2))
        else $error("class");
    AST_FACTOR: assert property (ow ##1 ce_i |=> ovl_factor_o == $past(wd[13:7], 2))
        else $error("factor");
    AST_BASE: assert property (ow ##1 ce_i |=> ovl_base_o == $past(wd[6:0], 2))
        else $error("base");
    AST_THRESH: assert property (ovl_threshold_o == ovl_factor_o * ovl_base_o)
        else $error("threshold");
    // unimplemented read bits and fault qualification
    AST_IN_HOLE: assert property (rd && req_i.addr == 2'h1 |=>
        (rdata_o & ~fpoc_pkg::MASK_IN_PERSIST) == 16'h0000) else $error("in holes");
    AST_OUT_HOLE: assert property (rd && req_i.addr == 2'h2 |=>
        (rdata_o & ~fpoc_pkg::MASK_OUT_PERSIST_ONE) == 16'h0000) else $error("out holes");
    AST_RISE: assert property ($rose(fault_o.in_uv) |-> $past(cv && cond_i.in_uv))
        else $error("rise");
    AST_CLEAR: assert property (cv && !cond_i.ld |=> !fault_o.ld) else $error("clear");
    // main scenarios
    CV_OVL: cover property (ow);
    CV_HOLE: cover property (rd && req_i.addr == 2'h3);
    CV_FAULT: cover property ($rose(fault_o.out_ov));
endmodule : fpoc_regs_props
bind fpoc_regs fpoc_regs_props i_fpoc_regs_props (.*);
`default_nettype wire

//--- testbench/fpoc_regs_bench.sv
// Purpose: self-checking bench for fpoc_regs
// Assumes: inputs change at falling edges, ce_i high except during the enable test
// Notes: expected reads and faults wait in queues
`timescale 1ns/10ps
`default_nettype none
module fpoc_regs_bench;
    logic clk_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1, req_valid_i = 1'h0, conv_en_i = 1'h0;
    logic conv_valid_i = 1'h0;
    logic [15:0] rdata_o, v, rq[$];
    logic [4:0] fq[$];
    logic [6:0] ovl_factor_o, ovl_base_o;
    logic [13:0] ovl_threshold_o;
    fpoc_pkg::fpoc_req_s req_i = '0;
    fpoc_pkg::fpoc_cond_s cond_i = '0, fault_o;
    fpoc_pkg::fpoc_class_e ovl_class_o;
    int fail_count = 0, checks_done = 0;
    // clock, device and result watcher
    always #20 clk_i = ~clk_i;
    fpoc_regs i_fpoc_regs (.*);
    always @(posedge clk_i) begin
        #5;
        if (req_valid_i && !req_i.wr) cmp_rd(rq.pop_front(), rdata_o);
        if (conv_valid_i) cmp_ft(fq.pop_front(), fault_o);
    end
    // one register access or one conversion sample
    task automatic acc(input logic wr, input logic [1:0] a, input logic [15:0] d, e);
        @(negedge clk_i) {req_i, req_valid_i} = {wr, a, d, 1'h1};
        if (!wr) rq.push_back(e);
        @(negedge clk_i) req_valid_i = 1'h0;
    endtask : acc
    task automatic conv(input logic [4:0] c, e);
        @(negedge clk_i) {cond_i, conv_valid_i} = {c, 1'h1};
        fq.push_back(e);
        @(negedge clk_i) {cond_i, conv_valid_i} = {~c, 1'h0};
    endtask : conv
    // compare read data and fault flags
    task automatic cmp_rd(input logic [15:0] e, s);
        checks_done++;
        if (s !== e) fail_count++;
        if (s !== e) $display("[FAIL] rdata_o expected %h seen %h", e, s);
    endtask : cmp_rd
    task automatic cmp_ft(input logic [4:0] e, s);
        checks_done++;
        if (s !== e) fail_count++;
        if (s !== e) $display("[FAIL] fault_o expected %h seen %h", e, s);
    endtask : cmp_ft
    // decoded overload outputs against the written word
    task automatic cmp_ovl(input logic [15:0] w);
        logic [31:0] e, s;
        e = {4'h1 << w[15:14], w[13:7], w[6:0], 14'(w[13:7]) * 14'(w[6:0])};
        s = {ovl_class_o, ovl_factor_o, ovl_base_o, ovl_threshold_o};
        checks_done++;
        if (s !== e) fail_count++;
        if (s !== e) $display("[FAIL] overload outputs expected %h seen %h", e, s);
    endtask : cmp_ovl
    // counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // watchdog far beyond the expected run
    initial begin
        #400000 fail_count++;
        print_verdict();
    end
    // reset values, overload fields, write lock, persistence counts
    initial begin
        v = 16'($urandom(67));
        #80 resetn_i = 1'h1;
        for (int a = 0; a < 4; a++) acc(1'h0, 2'(a), 16'h0000, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), 14'($urandom)};
            acc(1'h1, 2'h0, v, 16'h0000);
            acc(1'h0, 2'h0, 16'h0000, v);
            cmp_ovl(v);
        end
        $display("overload test done");
        acc(1'h1, 2'h1, v, 16'h0000);
        conv_en_i = 1'h1;
        acc(1'h1, 2'h1, ~v, 16'h0000);
        acc(1'h0, 2'h1, 16'h0000, v & fpoc_pkg::MASK_IN_PERSIST);
        conv_en_i = 1'h0;
        $display("lock test done");
        ce_i = 1'h0;
        acc(1'h1, 2'h0, ~v, 16'h0000);
        ce_i = 1'h1;
        acc(1'h0, 2'h0, 16'h0000, v);
        cmp_ovl(v);
        $display("enable test done");
        for (int c = 0; c < 7; c++) begin
            acc(1'h1, 2'h1, {3'(c), 2'h0, 3'(c), 3'(c), 5'h00}, v);
            acc(1'h1, 2'h2, {3'(c), 5'h00, 3'(c), 5'h00}, v);
            for (int k = 1; k < 1 << c; k++) conv(5'h1F, 5'h00);
            conv(5'h00, 5'h00);
            for (int k = 1; k <= 1 << c; k++) conv(5'h1F, {5{k == 1 << c && c < 6}});
            conv(5'h00, 5'h00);
        end
        $display("persistence test done");
        print_verdict();
    end
endmodule : fpoc_regs_bench
`default_nettype wire
